// File: smbus_pkg.sv
// Purpose: Shared constants for the SMBus master byte engine.
// Assumes: Byte-wide register port, addresses as in the register map.
// Notes:   Offsets, bit positions and reset values live here only.

// ==========================================================
// Package
package smbus_pkg;

  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  ADDR_CTRL  = 8'hC0;
  localparam logic [7:0]  ADDR_CFG   = 8'hC1;
  localparam logic [7:0]  ADDR_DATA  = 8'hC2;

  // Control/status bit positions
  localparam int          B_MASTER   = 7;
  localparam int          B_TRANSMITTER_ROLE_FLAG   = 6;
  localparam int          B_STA      = 5;
  localparam int          B_STO      = 4;
  localparam int          B_ACK_RESPONSE_NEEDED_FLAG    = 3;
  localparam int          B_ARBL     = 2;
  localparam int          B_ACK      = 1;
  localparam int          B_SI       = 0;

  // Configuration bit positions
  localparam int          B_ENABLE   = 7;
  localparam int          B_BUSY     = 5;

  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam int          SYNC_DEPTH = 2;

endpackage : smbus_pkg

// File: line_if.sv
// Purpose: Carries synchronised bus levels and conditions between modules.
// Assumes: All signals are on clk_sys.
// Notes:   Events are one-cycle pulses.

// ==========================================================
// Interface
interface line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic start_det;
  logic stop_det;

  modport src (output scl, sda, scl_rise, start_det, stop_det);
  modport snk (input  scl, sda, scl_rise, start_det, stop_det);
endinterface : line_if

// File: line_monitor.sv
// Purpose: Synchronises SCL/SDA and detects START, STOP and SCL rises.
// Assumes: Pins are asynchronous to clk_sys.
// Notes:   Only the last sync stage feeds any detection logic.

// ==========================================================
// Line monitor
module line_monitor #(
  parameter int STAGES = smbus_pkg::SYNC_DEPTH
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  line_if.src       mon
);
  import smbus_pkg::*;

  // Fewer than two stages would let a metastable level reach the detectors
  if (STAGES < 2) begin : g_stage_check
    $error("line_monitor needs at least two sync stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] scl_sync;
    logic [STAGES-1:0] sda_sync;
    logic              scl_prev;
    logic              sda_prev;
  } mon_t;

  mon_t q;
  mon_t d;

  // Shift chains; idle bus reads high
  always_comb begin
    d          = q;
    d.scl_sync = {q.scl_sync[STAGES-2:0], scl_i};
    d.sda_sync = {q.sda_sync[STAGES-2:0], sda_i};
    d.scl_prev = q.scl_sync[STAGES-1];
    d.sda_prev = q.sda_sync[STAGES-1];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  // Conditions seen only on settled levels
  assign mon.scl       = q.scl_sync[STAGES-1];
  assign mon.sda       = q.sda_sync[STAGES-1];
  assign mon.scl_rise  = mon.scl & ~q.scl_prev;
  assign mon.start_det = q.scl_prev & mon.scl & q.sda_prev & ~mon.sda;
  assign mon.stop_det  = q.scl_prev & mon.scl & ~q.sda_prev & mon.sda;

endmodule : line_monitor

// File: smbus_master.sv
// Purpose: SMBus master transmitter/receiver with control flags and data.
// Assumes: bit_tick is a one-cycle pulse on clk_sys from a timer overflow.
// Notes:   Slave data paths and timeouts live elsewhere.
//
// Strobed register access is this design's own decision.

module smbus_master (
  input  wire  logic                      clk_sys,
  input  wire  logic                      rst_n,
  input  wire  logic [smbus_pkg::ADDR_W-1:0] addr,
  input  wire  logic [7:0]                wdata,
  input  wire  logic                      wr_stb,
  input  wire  logic                      rd_stb,
  output logic       [7:0]                rdata,
  input  wire  logic                      bit_tick,
  input  wire  logic                      scl_i,
  output logic                            scl_o,
  output logic                            scl_oe_n,
  input  wire  logic                      sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_n
);
  import smbus_pkg::*;

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_n_int;

  // Async assert, two-flop release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  // ==========================================================
  // Bus line monitor
  line_if lines ();

  line_monitor #(
    .STAGES (SYNC_DEPTH)
  ) u_mon (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_int),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .mon     (lines)
  );

  // ==========================================================
  // State
  typedef enum logic [3:0] {
    S_IDLE, S_STA_A, S_STA_B, S_HOLD, S_ACK_LO, S_ACK_HI, S_DECIDE,
    S_BIT_LO, S_BIT_HI, S_RACK_LO, S_RACK_HI, S_STOP_A, S_STOP_B,
    S_STOP_C, S_RS_A, S_RS_B
  } st_t;

  typedef struct packed {
    st_t        st;
    logic       enable;
    logic       busy;
    logic       master;
    logic       transmitter_role_flag;
    logic       start_condition_flag;
    logic       stop_condition_flag;
    logic       ack_response_needed_flag;
    logic       arbl;
    logic       ack;
    logic       si;
    logic [7:0] buffer;
    logic       wrote;
    logic       first;
    logic [3:0] bitcnt;
    logic [3:0] listen;
    logic       scl_low;
    logic       sda_low;
    logic [7:0] rdata;
  } state_t;

  state_t q;
  state_t d;
  logic   own_start;
  logic   own_stop;
  logic   shifting;

  assign own_start = (q.st == S_STA_A) || (q.st == S_STA_B);
  assign own_stop  = (q.st == S_STOP_C);
  assign shifting  = q.st inside {S_BIT_LO, S_BIT_HI};

  // ==========================================================
  // Next state
  always_comb begin
    d       = q;
    d.rdata = 8'h00;

    // Register reads, answered next cycle
    if (rd_stb) begin
      unique case (addr)
        ADDR_CTRL: d.rdata = {q.master, q.transmitter_role_flag, q.start_condition_flag, q.stop_condition_flag,
                              q.ack_response_needed_flag, q.arbl, q.ack, q.si};
        ADDR_CFG:  d.rdata = {q.enable, 1'b0, q.busy, 5'b0_0000};
        ADDR_DATA: d.rdata = q.buffer;
        default:   d.rdata = 8'h00;
      endcase
    end

    // Software writes; hardware sets below win over them
    if (wr_stb) begin
      unique case (addr)
        ADDR_CTRL: begin
          d.start_condition_flag = wdata[B_STA];
          d.stop_condition_flag = wdata[B_STO];
          d.ack = wdata[B_ACK];
          d.si  = wdata[B_SI];
          if (q.si && !wdata[B_SI]) begin
            d.arbl = 1'b0;
          end
        end
        ADDR_CFG: d.enable = wdata[B_ENABLE];
        ADDR_DATA: begin
          // Never disturb a byte on the wire
          if (!shifting) begin
            d.buffer = wdata;
            d.wrote  = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Bus watching for foreign conditions
    if (lines.start_det && !own_start) begin
      d.busy   = 1'b1;
      d.transmitter_role_flag = 1'b0;
      d.listen = 4'h1;
      if (q.master && !q.start_condition_flag) begin
        d.master = 1'b0;
        d.arbl   = 1'b1;
        d.si     = 1'b1;
        d.st     = S_IDLE;
      end
    end else if (lines.start_det) begin
      d.busy = 1'b1;
    end
    if (lines.stop_det) begin
      d.busy   = 1'b0;
      d.listen = 4'h0;
      if (q.master && !own_stop) begin
        d.master = 1'b0;
        d.transmitter_role_flag = 1'b0;
        d.stop_condition_flag    = 1'b1;
        d.arbl   = 1'b1;
        d.si     = 1'b1;
        d.st     = S_IDLE;
      end
    end
    // Count address bits after a foreign START
    if (q.listen != 4'h0 && lines.scl_rise && !lines.start_det) begin
      if (q.listen == BYTE_BITS) begin
        d.start_condition_flag    = 1'b1;
        d.listen = 4'h0;
      end else begin
        d.listen = q.listen + 4'h1;
      end
    end

    // Master sequencer
    unique case (q.st)
      S_IDLE: begin
        if (q.enable && q.start_condition_flag && !q.busy && bit_tick) begin
          d.st = S_STA_A;
        end
      end
      S_STA_A: begin
        // SDA low with SCL high forms the START
        if (bit_tick) begin
          if (!lines.scl) begin
            d.master = 1'b0;
            d.arbl   = 1'b1;
            d.si     = 1'b1;
            d.st     = S_IDLE;
          end else begin
            d.st = S_STA_B;
          end
        end
      end
      S_STA_B: begin
        if (bit_tick) begin
          d.master = 1'b1;
          d.transmitter_role_flag = 1'b1;
          d.si     = 1'b1;
          d.first  = 1'b1;
          d.st     = S_HOLD;
        end
      end
      S_HOLD: begin
        // SCL stays low until software releases
        if (!q.si) begin
          d.st = q.ack_response_needed_flag ? S_ACK_LO : S_DECIDE;
        end
      end
      S_ACK_LO: begin
        if (bit_tick) begin
          d.st = S_ACK_HI;
        end
      end
      S_ACK_HI: begin
        if (bit_tick && lines.scl) begin
          d.ack_response_needed_flag = 1'b0;
          d.st    = S_DECIDE;
        end
      end
      S_DECIDE: begin
        d.first = 1'b0;
        if (q.stop_condition_flag) begin
          d.st = S_STOP_A;
        end else if (q.start_condition_flag && !q.first) begin
          d.st = S_RS_A;
        end else begin
          d.transmitter_role_flag = q.wrote;
          d.wrote  = 1'b0;
          d.bitcnt = 4'h0;
          d.st     = S_BIT_LO;
        end
      end
      S_BIT_LO: begin
        if (bit_tick) begin
          d.st = S_BIT_HI;
        end
      end
      S_BIT_HI: begin
        // Waits out clock stretching before sampling
        if (bit_tick && lines.scl) begin
          d.buffer = {q.buffer[6:0], lines.sda};
          d.bitcnt = q.bitcnt + 4'h1;
          if (q.transmitter_role_flag && q.buffer[7] && !lines.sda) begin
            d.master = 1'b0;
            d.transmitter_role_flag = 1'b0;
            d.arbl   = 1'b1;
            d.si     = 1'b1;
            d.listen = q.bitcnt + 4'h1;
            d.st     = S_IDLE;
          end else if (q.bitcnt + 4'h1 == BYTE_BITS) begin
            if (q.transmitter_role_flag) begin
              d.st = S_RACK_LO;
            end else begin
              d.ack_response_needed_flag = 1'b1;
              d.si    = 1'b1;
              d.st    = S_HOLD;
            end
          end else begin
            d.st = S_BIT_LO;
          end
        end
      end
      S_RACK_LO: begin
        if (bit_tick) begin
          d.st = S_RACK_HI;
        end
      end
      S_RACK_HI: begin
        if (bit_tick && lines.scl) begin
          d.ack = ~lines.sda;
          d.si  = 1'b1;
          d.st  = S_HOLD;
        end
      end
      S_STOP_A: begin
        if (bit_tick) begin
          d.st = S_STOP_B;
        end
      end
      S_STOP_B: begin
        if (bit_tick && lines.scl) begin
          d.st = S_STOP_C;
        end
      end
      S_STOP_C: begin
        if (bit_tick) begin
          d.master = 1'b0;
          d.transmitter_role_flag = 1'b0;
          if (!lines.scl) begin
            d.arbl = 1'b1;
            d.si   = 1'b1;
          end else begin
            d.stop_condition_flag = 1'b0;
          end
          // A set start flag restarts from idle once the bus frees
          d.st = S_IDLE;
        end
      end
      S_RS_A: begin
        if (bit_tick) begin
          d.st = S_RS_B;
        end
      end
      S_RS_B: begin
        if (bit_tick && lines.scl) begin
          d.st = S_STA_A;
        end
      end
    endcase

    // Disabled interface drops off the bus
    if (!q.enable) begin
      d.st     = S_IDLE;
      d.master = 1'b0;
    end

    // Pin drive from the next state; SDA only low in owned phases
    d.scl_low = d.st inside {S_STA_B, S_HOLD, S_ACK_LO, S_DECIDE,
                             S_BIT_LO, S_RACK_LO, S_STOP_A, S_RS_A};
    unique case (d.st)
      S_STA_A, S_STA_B, S_STOP_A, S_STOP_B: d.sda_low = 1'b1;
      S_BIT_LO, S_BIT_HI: d.sda_low = d.transmitter_role_flag & ~d.buffer[7];
      S_ACK_LO, S_ACK_HI: d.sda_low = q.ack;
      default:            d.sda_low = 1'b0;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      q        <= '0;
      q.st     <= S_IDLE;
      q.buffer <= DATA_RST;
      {q.master, q.transmitter_role_flag, q.start_condition_flag, q.stop_condition_flag,
       q.ack_response_needed_flag, q.arbl, q.ack, q.si} <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs; open-drain, enable low while pulling down
  assign rdata    = q.rdata;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = ~q.scl_low;
  assign sda_oe_n = ~q.sda_low;

endmodule : smbus_master

// File: smbus_master_checker.sv
// Purpose: Port-level assertions for the SMBus master.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   Bound to every smbus_master instance.

// ==========================================================
// Checker
module smbus_master_checker (
  input wire logic                          clk_sys,
  input wire logic                          rst_n,
  input wire logic [smbus_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                    wdata,
  input wire logic                          wr_stb,
  input wire logic                          rd_stb,
  input wire logic [7:0]                    rdata,
  input wire logic                          bit_tick,
  input wire logic                          scl_i,
  input wire logic                          scl_o,
  input wire logic                          scl_oe_n,
  input wire logic                          sda_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import smbus_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Mirror of the enable bit; pins must stay quiet until it is set
  logic en_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_q <= 1'b0;
    else if (wr_stb && addr == ADDR_CFG) en_q <= wdata[B_ENABLE];
  end

  // ==========================================================
  // Sequences
  sequence s_data_wr;
    wr_stb && addr == ADDR_DATA;
  endsequence
  sequence s_data_rd;
    rd_stb && addr == ADDR_DATA;
  endsequence
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  sequence s_stop;
    $rose(sda_oe_n) && scl_oe_n;
  endsequence

  // ==========================================================
  // Assertions
  a_rdata_idle_zero: assert property (
    !$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_data_read_back: assert property (
    s_data_wr ##1 s_data_rd |=> rdata == $past(wdata, 2))
    else $error("data register read back wrong");
  a_pins_open_drain: assert property (
    scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  a_scl_on_tick: assert property (
    $changed(scl_oe_n) |-> $past(bit_tick) || $past(bit_tick, 2))
    else $error("clock moved without tick");
  a_start_order: assert property (
    s_start |-> !sda_oe_n throughout (##[1:64] $fell(scl_oe_n)))
    else $error("start not followed by clock low");
  a_stop_idle: assert property (
    s_stop |=> (scl_oe_n && sda_oe_n) [*8])
    else $error("bus not idle after stop");
  a_reset_idle: assert property (
    $rose(rst_n) |-> scl_oe_n && sda_oe_n)
    else $error("lines driven at reset release");
  a_disabled_quiet: assert property (
    !en_q |=> scl_oe_n && sda_oe_n)
    else $error("lines driven while disabled");
endmodule : smbus_master_checker

bind smbus_master smbus_master_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .bit_tick(bit_tick), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n));

// File: smbus_slave_model.sv
// Purpose: Behavioural SMBus slave on the far side of the master.
// Assumes: Lines have pull-ups; released lines read high.
// Notes:   Acks the address and every byte of a write frame, sends tx_byte on reads.

// ==========================================================
// Slave model
module smbus_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  output logic            pull,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 100ps;
  int         n = -1;
  logic       addr_ph = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;

  initial pull = 1'b0;

  // START restarts the frame; STOP parks the model
  // SDA may move in the step in which SCL falls: look again a moment later
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      #1;
      if (scl === 1'b1 && sda === 1'b0) begin
        n = 0;
        addr_ph = 1'b1;
        rd = 1'b0;
      end
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      #1;
      if (scl === 1'b1 && sda === 1'b1) n = -1;
    end
  end

  // Sample on clock rise; a not-ack from the master ends a read
  always @(posedge scl) begin
    if (n >= 0 && n < 8) begin
      sh = {sh[6:0], sda};
      n = n + 1;
      if (n == 8) got = sh;
    end else if (n == 8) begin
      if (addr_ph) rd = sh[0];
      n = (!addr_ph && rd && sda) ? -1 : 0;
      addr_ph = 1'b0;
    end
  end

  // Change SDA only while the clock is low
  always @(negedge scl) begin
    if (n == 8 && (addr_ph || !rd)) pull = 1'b1;
    else if (n >= 0 && n < 8 && rd && !addr_ph) pull = !tx_byte[7 - n];
    else pull = 1'b0;
  end
endmodule : smbus_slave_model

// File: smbus_master_transfer_and_status_test.sv
// Purpose: Self-checking bench for the SMBus master.
// Assumes: One slave on the bus, pull-ups on both lines.
// Notes:   Bit tick every 16 clocks, near a 125 ns link period.

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

// ==========================================================
// Testbench
module smbus_master_transfer_and_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  import smbus_pkg::*;
  logic       clk_sys, rst_n, wr_stb, rd_stb;
  logic       bit_tick = 1'b0;
  logic       scl_i = 1'b1;
  logic       sda_i = 1'b1;
  logic [7:0] addr, wdata, rdata, slv_tx, got;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, pull;
  logic [3:0] tcnt = 4'h0;
  int         errors, n_checks, cyc;
  wire        scl_w = scl_oe_n;
  wire        sda_w = sda_oe_n & ~pull;

  smbus_master dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .bit_tick(bit_tick), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n));
  smbus_slave_model slv (.scl(scl_w), .sda(sda_w), .tx_byte(slv_tx),
    .pull(pull), .got(got));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Bit pacing, line sampling and hang guard
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 4'h1;
    bit_tick <= (tcnt == 4'hF);
    scl_i <= scl_w;
    sda_i <= sda_w;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (wr_stb === 1'b1) @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys);
  endtask : rd

  // Poll control until a bit reaches the wanted level
  task automatic wait_bit(input int b, input logic v);
    logic [7:0] c;
    int k;
    k = 0;
    do begin
      rd(ADDR_CTRL, c);
      k++;
    end while (c[b] !== v && k < 3000);
    `CHK(c[b], v)
  endtask : wait_bit

  // Send one byte as master transmitter and judge the outcome
  task automatic send(input logic [7:0] b);
    logic [7:0] d;
    wr(ADDR_DATA, b);
    wr(ADDR_CTRL, 8'h00);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d, 8'hC3)
    `CHK(got, b)
    rd(ADDR_DATA, d);
    `CHK(d, b)
  endtask : send

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_CTRL, d);
    `CHK(d, CTRL_RST)
    rd(ADDR_DATA, d);
    `CHK(d, DATA_RST)
    wr(ADDR_DATA, 8'h3C);
    rd(ADDR_DATA, d);
    `CHK(d, 8'h3C)
    rd(8'hC7, d);
    `CHK(d, 8'h00)
  endtask : t_regs

  task automatic t_write();
    logic [7:0] d;
    wr(ADDR_CFG, 8'h80);
    wr(ADDR_CTRL, 8'h20);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d, 8'hE1)
    `CHK(scl_oe_n, 1'b0)
    rd(ADDR_CFG, d);
    `CHK(d, 8'hA0)
    send(8'hA4);
    send(8'h96);
  endtask : t_write

  task automatic t_read();
    logic [7:0] d;
    wr(ADDR_CTRL, 8'h20);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d, 8'hE1)
    send(8'hA5);
    wr(ADDR_CTRL, 8'h00);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d & 8'hFD, 8'h89)
    rd(ADDR_DATA, d);
    `CHK(d, 8'h5A)
    slv_tx <= 8'h3B;
    wr(ADDR_CTRL, 8'h02);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d & 8'hFD, 8'h89)
    rd(ADDR_DATA, d);
    `CHK(d, 8'h3B)
    wr(ADDR_CTRL, 8'h10);
    wait_bit(B_MASTER, 1'b0);
    rd(ADDR_CTRL, d);
    `CHK(d & 8'hF0, 8'h00)
  endtask : t_read

  // Receive, turn to transmit by a data write, then STOP with START behind
  task automatic t_restart();
    logic [7:0] d;
    slv_tx <= 8'hFF;
    wr(ADDR_CTRL, 8'h20);
    wait_bit(B_SI, 1'b1);
    send(8'hA5);
    wr(ADDR_CTRL, 8'h00);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_DATA, d);
    `CHK(d, 8'hFF)
    wr(ADDR_DATA, 8'h66);
    wr(ADDR_CTRL, 8'h02);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d, 8'hC1)
    `CHK(got, 8'h66)
    rd(ADDR_DATA, d);
    `CHK(d, 8'h66)
    wr(ADDR_CTRL, 8'h30);
    wait_bit(B_SI, 1'b1);
    rd(ADDR_CTRL, d);
    `CHK(d, 8'hE1)
    wr(ADDR_CTRL, 8'h10);
    wait_bit(B_MASTER, 1'b0);
    rd(ADDR_CTRL, d);
    `CHK(d & 8'hF0, 8'h00)
    rd(ADDR_CFG, d);
    `CHK(d, 8'h80)
  endtask : t_restart

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    {rst_n, wr_stb, rd_stb} = 3'b000;
    {addr, wdata} = 16'h0000;
    slv_tx = 8'h5A;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_write();
    t_read();
    t_restart();
    give_verdict();
  end
endmodule : smbus_master_transfer_and_status_test
